// ==== logic/eag_index_scale.sv ====
// forms the sized, sign-extended and scaled index operand
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.svh"

module eag_index_scale (
  input  wire logic [15:0] ext_word,
  input  wire logic [31:0] idx_data,
  input  wire logic        suppress,
  output logic      [31:0] scaled_index_operand
);

  logic [31:0] idx_value;

  always_comb begin
    idx_value = ext_word[`EAG_X_WL] ? idx_data
                                    : eag_pkg::eag_sext16(idx_data[15:0]);
    scaled_index_operand = idx_value << ext_word[`EAG_X_SC_HI:`EAG_X_SC_LO];
    if (suppress) begin
      scaled_index_operand = `EAG_ZERO32;
    end
  end

endmodule : eag_index_scale
`default_nettype wire

// ==== logic/eag_map.svh ====
// constants for the effective address generator: field positions, codes, sizes
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH

// ----------------------------------------------------------------------
// mode subfield codes
// ----------------------------------------------------------------------
`define EAG_MODE_DREG    3'h0
`define EAG_MODE_AREG    3'h1
`define EAG_MODE_IND     3'h2
`define EAG_MODE_POST    3'h3
`define EAG_MODE_PRE     3'h4
`define EAG_MODE_DISP    3'h5
`define EAG_MODE_INDEX   3'h6
`define EAG_MODE_SPECIAL 3'h7

// ----------------------------------------------------------------------
// submode codes under the special mode
// ----------------------------------------------------------------------
`define EAG_SUB_ABSW     3'h0
`define EAG_SUB_ABSL     3'h1
`define EAG_SUB_PCDISP   3'h2
`define EAG_SUB_PCIDX    3'h3
`define EAG_SUB_IMM      3'h4

// ----------------------------------------------------------------------
// extension word field positions
// ----------------------------------------------------------------------
`define EAG_X_DA         15
`define EAG_X_REG_HI     14
`define EAG_X_REG_LO     12
`define EAG_X_WL         11
`define EAG_X_SC_HI      10
`define EAG_X_SC_LO      9
`define EAG_X_FULL       8
`define EAG_X_BS         7
`define EAG_X_IS         6
`define EAG_X_BD_HI      5
`define EAG_X_BD_LO      4
`define EAG_BD_WORD      2'h2
`define EAG_BD_LONG      2'h3

// ----------------------------------------------------------------------
// stack pointer register number and 32-bit zero value
// ----------------------------------------------------------------------
`define EAG_SP_NUM       3'h7
`define EAG_ZERO32       32'h0000_0000

`endif

// ==== logic/eag_mode_decode.sv ====
// splits the effective address field and classifies the addressing mode
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.svh"

module eag_mode_decode (
  input  wire logic [5:0]       ea_field,
  output var eag_pkg::eag_mode_t mode,
  output logic      [2:0]       reg_num
);

  logic [2:0] mode_bits;

  always_comb begin
    mode_bits = ea_field[5:3];
    reg_num   = ea_field[2:0];
    if (mode_bits == `EAG_MODE_DREG) begin
      mode = eag_pkg::M_DREG;
    end else if (mode_bits == `EAG_MODE_AREG) begin
      mode = eag_pkg::M_AREG;
    end else if (mode_bits == `EAG_MODE_IND) begin
      mode = eag_pkg::M_IND;
    end else if (mode_bits == `EAG_MODE_POST) begin
      mode = eag_pkg::M_POST;
    end else if (mode_bits == `EAG_MODE_PRE) begin
      mode = eag_pkg::M_PRE;
    end else if (mode_bits == `EAG_MODE_DISP) begin
      mode = eag_pkg::M_DISP;
    end else if (mode_bits == `EAG_MODE_INDEX) begin
      mode = eag_pkg::M_INDEX;
    end else if (reg_num == `EAG_SUB_ABSW) begin
      mode = eag_pkg::M_ABSW;
    end else if (reg_num == `EAG_SUB_ABSL) begin
      mode = eag_pkg::M_ABSL;
    end else if (reg_num == `EAG_SUB_PCDISP) begin
      mode = eag_pkg::M_PCDISP;
    end else if (reg_num == `EAG_SUB_PCIDX) begin
      mode = eag_pkg::M_PCIDX;
    end else if (reg_num == `EAG_SUB_IMM) begin
      mode = eag_pkg::M_IMM;
    end else begin
      mode = eag_pkg::M_BAD;
    end
  end

endmodule : eag_mode_decode
`default_nettype wire

// ==== logic/eag_pkg.sv ====
// types for the effective address generator
package eag_pkg;

  // --------------------------------------------------------------------
  // operand size
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } eag_size_t;

  // --------------------------------------------------------------------
  // decoded addressing class
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    M_DREG, M_AREG, M_IND, M_POST, M_PRE, M_DISP, M_INDEX,
    M_ABSW, M_ABSL, M_PCDISP, M_PCIDX, M_IMM, M_BAD
  } eag_mode_t;

  // --------------------------------------------------------------------
  // sequencer states, gray along idle, fetch, done
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_DONE  = 2'h3
  } eag_state_t;

  function automatic logic [31:0] eag_sext16(input logic [15:0] v);
    eag_sext16 = {{16{v[15]}}, v};
  endfunction : eag_sext16

endpackage : eag_pkg

// ==== logic/eag_top.sv ====
// effective address generator: decodes an ea field and computes the operand location
`timescale 1ns/10ps
`default_nettype none
`include "eag_map.svh"

module eag_top (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                start,
  input  wire logic [5:0]          ea_field,
  input  wire eag_pkg::eag_size_t  op_size,
  input  wire logic                jump_op,
  input  wire logic                write_op,
  input  wire logic [15:0]         ext_word0,
  input  wire logic [15:0]         ext_word1,
  input  wire logic [15:0]         ext_word2,
  input  wire logic [31:0]         ext_addr,
  input  wire logic [31:0]         base_data,
  input  wire logic [31:0]         idx_data,
  output logic                     busy,
  output logic                     done,
  output logic      [3:0]          base_sel,
  output logic      [3:0]          idx_sel,
  output logic      [31:0]         ea_addr,
  output logic                     reg_direct,
  output logic      [3:0]          operand_reg,
  output logic                     prog_space,
  output logic                     write_fault,
  output logic                     illegal,
  output logic                     imm_valid,
  output logic      [31:0]         imm_data,
  output logic                     wb_valid,
  output logic      [2:0]          wb_reg,
  output logic      [31:0]         wb_data,
  output logic      [2:0]          ext_count
);

  // --------------------------------------------------------------------
  // latched request and sequencer state
  // --------------------------------------------------------------------
  eag_pkg::eag_state_t state, next_state;
  logic [5:0]          l_ea, next_l_ea;
  eag_pkg::eag_size_t  l_size, next_l_size;
  logic                l_jump, next_l_jump;
  logic                l_write, next_l_write;
  logic [15:0]         l_x0, next_l_x0;
  logic [15:0]         l_x1, next_l_x1;
  logic [15:0]         l_x2, next_l_x2;
  logic [31:0]         l_pc, next_l_pc;
  logic [3:0]          next_base_sel, next_idx_sel;

  // --------------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------------
  logic                next_busy, next_done, next_reg_direct, next_prog_space;
  logic                next_write_fault, next_illegal, next_imm_valid, next_wb_valid;
  logic [31:0]         next_ea_addr, next_imm_data, next_wb_data;
  logic [3:0]          next_operand_reg;
  logic [2:0]          next_wb_reg, next_ext_count;

  eag_pkg::eag_mode_t  mode;
  logic [2:0]          reg_num;
  logic [31:0]         index_op, step, base_val, bd_val, disp8;
  logic                full_fmt, idx_supp, base_supp;
  logic [2:0]          bd_words;

  // --------------------------------------------------------------------
  // sub-blocks
  // --------------------------------------------------------------------
  eag_mode_decode u_decode (
    .ea_field (l_ea),
    .mode     (mode),
    .reg_num  (reg_num)
  );

  eag_index_scale u_index (
    .ext_word             (l_x0),
    .idx_data             (idx_data),
    .suppress             (idx_supp),
    .scaled_index_operand (index_op)
  );

  // --------------------------------------------------------------------
  // extension word fields
  // --------------------------------------------------------------------
  always_comb begin
    full_fmt  = l_x0[`EAG_X_FULL];
    idx_supp  = full_fmt & l_x0[`EAG_X_IS];
    base_supp = full_fmt & l_x0[`EAG_X_BS];
    disp8     = {{24{l_x0[7]}}, l_x0[7:0]};
    bd_words  = 3'h0;
    bd_val    = `EAG_ZERO32;
    if (l_x0[`EAG_X_BD_HI:`EAG_X_BD_LO] == `EAG_BD_WORD) begin
      bd_words = 3'h1;
      bd_val   = eag_pkg::eag_sext16(l_x1);
    end else if (l_x0[`EAG_X_BD_HI:`EAG_X_BD_LO] == `EAG_BD_LONG) begin
      bd_words = 3'h2;
      bd_val   = {l_x1, l_x2};
    end
    // postincrement and predecrement step, word step for a byte on the stack
    if (l_size == eag_pkg::SZ_LONG) begin
      step = 32'h0000_0004;
    end else if (l_size == eag_pkg::SZ_WORD || reg_num == `EAG_SP_NUM) begin
      step = 32'h0000_0002;
    end else begin
      step = 32'h0000_0001;
    end
    // pc-relative base is the extension word address unless suppressed
    base_val = base_supp ? `EAG_ZERO32 : base_data;
    if (mode == eag_pkg::M_PCDISP || mode == eag_pkg::M_PCIDX) begin
      base_val = base_supp ? `EAG_ZERO32 : l_pc;
    end
  end

  // --------------------------------------------------------------------
  // sequencer and address computation
  // --------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_l_ea        = l_ea;
    next_l_size      = l_size;
    next_l_jump      = l_jump;
    next_l_write     = l_write;
    next_l_x0        = l_x0;
    next_l_x1        = l_x1;
    next_l_x2        = l_x2;
    next_l_pc        = l_pc;
    next_base_sel    = base_sel;
    next_idx_sel     = idx_sel;
    next_busy        = busy;
    next_done        = 1'b0;
    next_ea_addr     = ea_addr;
    next_reg_direct  = reg_direct;
    next_operand_reg = operand_reg;
    next_prog_space  = prog_space;
    next_write_fault = write_fault;
    next_illegal     = illegal;
    next_imm_valid   = imm_valid;
    next_imm_data    = imm_data;
    next_wb_valid    = wb_valid;
    next_wb_reg      = wb_reg;
    next_wb_data     = wb_data;
    next_ext_count   = ext_count;
    case (state)
      eag_pkg::ST_IDLE: begin
        if (start) begin
          next_state    = eag_pkg::ST_FETCH;
          next_busy     = 1'b1;
          next_l_ea     = ea_field;
          next_l_size   = op_size;
          next_l_jump   = jump_op;
          next_l_write  = write_op;
          next_l_x0     = ext_word0;
          next_l_x1     = ext_word1;
          next_l_x2     = ext_word2;
          next_l_pc     = ext_addr;
          next_base_sel = {1'b1, ea_field[2:0]};
          next_idx_sel  = {ext_word0[`EAG_X_DA],
                           ext_word0[`EAG_X_REG_HI:`EAG_X_REG_LO]};
        end
      end
      eag_pkg::ST_FETCH: begin
        next_state       = eag_pkg::ST_DONE;
        next_done        = 1'b1;
        next_busy        = 1'b0;
        next_ea_addr     = `EAG_ZERO32;
        next_reg_direct  = 1'b0;
        next_operand_reg = {l_ea[3], reg_num};
        next_prog_space  = 1'b0;
        next_illegal     = 1'b0;
        next_imm_valid   = 1'b0;
        next_imm_data    = `EAG_ZERO32;
        next_wb_valid    = 1'b0;
        next_wb_reg      = reg_num;
        next_wb_data     = `EAG_ZERO32;
        next_ext_count   = 3'h0;
        case (mode)
          eag_pkg::M_DREG, eag_pkg::M_AREG: begin
            next_reg_direct = 1'b1;
          end
          eag_pkg::M_IND: begin
            next_ea_addr = base_data;
          end
          eag_pkg::M_POST: begin
            next_ea_addr  = base_data;
            next_wb_valid = 1'b1;
            next_wb_data  = base_data + step;
          end
          eag_pkg::M_PRE: begin
            next_ea_addr  = base_data - step;
            next_wb_valid = 1'b1;
            next_wb_data  = base_data - step;
          end
          eag_pkg::M_DISP: begin
            next_ea_addr   = base_data + eag_pkg::eag_sext16(l_x0);
            next_ext_count = 3'h1;
          end
          eag_pkg::M_INDEX, eag_pkg::M_PCIDX: begin
            if (full_fmt) begin
              next_ea_addr   = base_val + index_op + bd_val;
              next_ext_count = 3'h1 + bd_words;
            end else begin
              next_ea_addr   = base_val + disp8 + index_op;
              next_ext_count = 3'h1;
            end
            next_prog_space = (mode == eag_pkg::M_PCIDX) | l_jump;
          end
          eag_pkg::M_PCDISP: begin
            next_ea_addr    = l_pc + eag_pkg::eag_sext16(l_x0);
            next_prog_space = 1'b1;
            next_ext_count  = 3'h1;
          end
          eag_pkg::M_ABSW: begin
            next_ea_addr   = eag_pkg::eag_sext16(l_x0);
            next_ext_count = 3'h1;
          end
          eag_pkg::M_ABSL: begin
            next_ea_addr   = {l_x0, l_x1};
            next_ext_count = 3'h2;
          end
          eag_pkg::M_IMM: begin
            next_imm_valid  = 1'b1;
            next_prog_space = 1'b1;
            next_ext_count  = 3'h1;
            if (l_size == eag_pkg::SZ_LONG) begin
              next_imm_data  = {l_x0, l_x1};
              next_ext_count = 3'h2;
            end else if (l_size == eag_pkg::SZ_WORD) begin
              next_imm_data = {16'h0000, l_x0};
            end else begin
              next_imm_data = {24'h00_0000, l_x0[7:0]};
            end
          end
          default: begin
            next_illegal = 1'b1;
          end
        endcase
        // pc-relative and immediate operands may only be read
        next_write_fault = l_write & (mode == eag_pkg::M_PCDISP ||
                           mode == eag_pkg::M_PCIDX || mode == eag_pkg::M_IMM);
      end
      eag_pkg::ST_DONE: begin
        next_state    = eag_pkg::ST_IDLE;
        next_wb_valid = 1'b0;
      end
      default: begin
        next_state = eag_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= eag_pkg::ST_IDLE;
      l_ea        <= 6'h00;
      l_size      <= eag_pkg::SZ_BYTE;
      l_jump      <= 1'b0;
      l_write     <= 1'b0;
      l_x0        <= 16'h0000;
      l_x1        <= 16'h0000;
      l_x2        <= 16'h0000;
      l_pc        <= `EAG_ZERO32;
      base_sel    <= 4'h0;
      idx_sel     <= 4'h0;
      busy        <= 1'b0;
      done        <= 1'b0;
      ea_addr     <= `EAG_ZERO32;
      reg_direct  <= 1'b0;
      operand_reg <= 4'h0;
      prog_space  <= 1'b0;
      write_fault <= 1'b0;
      illegal     <= 1'b0;
      imm_valid   <= 1'b0;
      imm_data    <= `EAG_ZERO32;
      wb_valid    <= 1'b0;
      wb_reg      <= 3'h0;
      wb_data     <= `EAG_ZERO32;
      ext_count   <= 3'h0;
    end else begin
      state       <= next_state;
      l_ea        <= next_l_ea;
      l_size      <= next_l_size;
      l_jump      <= next_l_jump;
      l_write     <= next_l_write;
      l_x0        <= next_l_x0;
      l_x1        <= next_l_x1;
      l_x2        <= next_l_x2;
      l_pc        <= next_l_pc;
      base_sel    <= next_base_sel;
      idx_sel     <= next_idx_sel;
      busy        <= next_busy;
      done        <= next_done;
      ea_addr     <= next_ea_addr;
      reg_direct  <= next_reg_direct;
      operand_reg <= next_operand_reg;
      prog_space  <= next_prog_space;
      write_fault <= next_write_fault;
      illegal     <= next_illegal;
      imm_valid   <= next_imm_valid;
      imm_data    <= next_imm_data;
      wb_valid    <= next_wb_valid;
      wb_reg      <= next_wb_reg;
      wb_data     <= next_wb_data;
      ext_count   <= next_ext_count;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_take;
    start && state == eag_pkg::ST_IDLE;
  endsequence

  a_done_latency: assert property (s_take |-> ##2 done)
    else $error("done not two cycles after start");
  a_sp_post_step: assert property (done && wb_valid && wb_reg == `EAG_SP_NUM
      && l_size == eag_pkg::SZ_BYTE && l_ea[5:3] == `EAG_MODE_POST
      |-> wb_data == ea_addr + 32'h0000_0002)
    else $error("byte stack postincrement not by two");
  a_pre_addr: assert property (done && l_ea[5:3] == `EAG_MODE_PRE
      |-> wb_valid && wb_data == ea_addr)
    else $error("predecrement address differs from writeback");
  a_post_long: assert property (done && l_ea[5:3] == `EAG_MODE_POST
      && l_size == eag_pkg::SZ_LONG |-> wb_data == ea_addr + 32'h0000_0004)
    else $error("long postincrement not by four");
  a_regdir_nomem: assert property (done && l_ea[5:4] == 2'h0
      |-> reg_direct && operand_reg == l_ea[3:0] && !wb_valid)
    else $error("register direct mis-decoded");
  a_pc_prog: assert property (done && l_ea == 6'h3a
      |-> prog_space && ea_addr == l_pc + eag_pkg::eag_sext16(l_x0))
    else $error("pc displacement wrong");
  a_pc_nowrite: assert property (done && l_write && l_ea[5:1] == 5'h1d
      |-> write_fault)
    else $error("pc relative write not flagged");
  a_index_space: assert property (done && l_ea[5:3] == `EAG_MODE_INDEX
      |-> prog_space == l_jump)
    else $error("indexed space class wrong");
  a_abs_short: assert property (done && l_ea == 6'h38
      |-> ea_addr == {{16{l_x0[15]}}, l_x0})
    else $error("absolute short not sign extended");
  a_abs_long: assert property (done && l_ea == 6'h39
      |-> ea_addr == {l_x0, l_x1} && ext_count == 3'h2)
    else $error("absolute long order wrong");
  a_imm_long: assert property (done && l_ea == 6'h3c && l_size == eag_pkg::SZ_LONG
      |-> imm_valid && imm_data == {l_x0, l_x1})
    else $error("long immediate wrong");
  a_disp_add: assert property (done && l_ea[5:3] == `EAG_MODE_DISP
      |-> ea_addr == $past(base_data) + {{16{l_x0[15]}}, l_x0})
    else $error("displacement sum wrong");
  a_idx_sel: assert property (s_take |=> idx_sel == {$past(ext_word0[15]),
      $past(ext_word0[14:12])})
    else $error("index register select wrong");

endmodule : eag_top
`default_nettype wire

// ==== tb/eag_regfile_model.sv ====
// register file model that answers the base and index reads
`timescale 1ns/10ps
`default_nettype none

module eag_regfile_model (
  input  wire logic [3:0]  base_sel,
  input  wire logic [3:0]  idx_sel,
  output logic      [31:0] base_data,
  output logic      [31:0] idx_data
);
  // ----------------------------------------------------------------------
  // contents: data regs have a positive low word, address regs a negative
  // ----------------------------------------------------------------------
  logic [31:0] regs [16];

  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h0010_08f0 + (i << 12);
    end
  end

  assign base_data = regs[base_sel];
  assign idx_data  = regs[idx_sel];
endmodule : eag_regfile_model
`default_nettype wire

// ==== tb/effective_address_generator_tb_top.sv ====
// self-checking testbench for the effective address generator
`timescale 1ns/10ps
`default_nettype none

module effective_address_generator_tb_top;
  localparam eag_pkg::eag_size_t sb = eag_pkg::SZ_BYTE;
  localparam eag_pkg::eag_size_t sw = eag_pkg::SZ_WORD;
  localparam eag_pkg::eag_size_t sl = eag_pkg::SZ_LONG;
  logic               clk = 1'b0, rstn = 1'b0, start = 1'b0, jump_op = 1'b0, write_op = 1'b0;
  logic [5:0]         ea_field = 6'h00;
  logic [15:0]        ext_word0 = 16'h0000, ext_word1 = 16'h0000, ext_word2 = 16'h0000;
  logic [31:0]        ext_addr = 32'h0002_0000;
  eag_pkg::eag_size_t op_size = sw;
  logic [31:0]        base_data, idx_data, ea_addr, imm_data, wb_data;
  logic [3:0]         base_sel, idx_sel, operand_reg;
  logic [2:0]         wb_reg, ext_count;
  logic               busy, done, reg_direct, prog_space, write_fault, illegal, imm_valid, wb_valid;
  int                 fails = 0, check_count = 0;

  always #4 clk = ~clk;

  eag_top u_eag_top (.clk, .rstn, .start, .ea_field, .op_size, .jump_op, .write_op,
    .ext_word0, .ext_word1, .ext_word2, .ext_addr, .base_data, .idx_data, .busy, .done,
    .base_sel, .idx_sel, .ea_addr, .reg_direct, .operand_reg, .prog_space, .write_fault,
    .illegal, .imm_valid, .imm_data, .wb_valid, .wb_reg, .wb_data, .ext_count);
  eag_regfile_model u_eag_regfile_model (.base_sel, .idx_sel, .base_data, .idx_data);

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] r(input int k);
    return u_eag_regfile_model.regs[k];
  endfunction : r

  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sx

  // one request, then wait for done and check its latency
  task automatic go(input logic [5:0] ea, input eag_pkg::eag_size_t sz, input logic [15:0] e0,
                    input logic [15:0] e1 = 16'h0000, input logic [15:0] e2 = 16'h0000);
    int n;
    @(posedge clk);
    start     <= 1'b1;
    ea_field  <= ea;
    op_size   <= sz;
    ext_word0 <= e0;
    ext_word1 <= e1;
    ext_word2 <= e2;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n == 1) begin
        chk({31'h0, busy}, 32'h1);
      end
    end while (done !== 1'b1 && n < 8);
    chk(32'(n), 32'h2);
    chk({31'h0, busy}, 32'h0);
  endtask : go

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_direct;
    go(6'h03, sl, 16'h0000);
    chk({27'h0, reg_direct, operand_reg}, 32'h13);
    go(6'h0d, sw, 16'h0000);
    chk({27'h0, reg_direct, operand_reg}, 32'h1d);
  endtask : t_direct

  task automatic t_step;
    go(6'h1a, sl, 16'h0000);
    chk(ea_addr, r(10));
    chk({28'h0, wb_valid, wb_reg}, 32'ha);
    chk(wb_data, r(10) + 32'h4);
    go(6'h19, sw, 16'h0000);
    chk(wb_data, r(9) + 32'h2);
    go(6'h19, sb, 16'h0000);
    chk(wb_data, r(9) + 32'h1);
    go(6'h1f, sb, 16'h0000);
    chk(wb_data, r(15) + 32'h2);
    go(6'h21, sw, 16'h0000);
    chk(ea_addr, r(9) - 32'h2);
    chk(wb_data, r(9) - 32'h2);
    go(6'h22, sl, 16'h0000);
    chk(ea_addr, r(10) - 32'h4);
    go(6'h27, sb, 16'h0000);
    chk(ea_addr, r(15) - 32'h2);
    go(6'h14, sw, 16'h0000);
    chk(ea_addr, r(12));
    chk({31'h0, wb_valid}, 32'h0);
  endtask : t_step

  task automatic t_index;
    go(6'h2b, sw, 16'hfff0);
    chk(ea_addr, r(11) + 32'hffff_fff0);
    go(6'h30, sw, 16'ha680);
    chk({28'h0, idx_sel}, 32'ha);
    chk(ea_addr, r(8) + (sx(16'(r(10))) << 3) + 32'hffff_ff80);
    chk({31'h0, prog_space}, 32'h0);
    @(posedge clk);
    jump_op <= 1'b1;
    go(6'h30, sw, 16'ha680);
    chk({31'h0, prog_space}, 32'h1);
    @(posedge clk);
    jump_op <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      go(6'h30, sw, 16'h3804 | 16'(s << 9));
      chk(ea_addr, r(8) + (r(3) << s) + 32'h4);
    end
    go(6'h31, sw, 16'h1d30, 16'hffff, 16'hfff0);
    chk(ea_addr, r(9) + (r(1) << 2) + 32'hffff_fff0);
    chk({29'h0, ext_count}, 32'h3);
    go(6'h31, sw, 16'h1d20, 16'h0100);
    chk(ea_addr, r(9) + (r(1) << 2) + 32'h100);
  endtask : t_index

  task automatic t_pcrel;
    @(posedge clk);
    write_op <= 1'b1;
    go(6'h3a, sw, 16'h8000);
    chk(ea_addr, 32'h0001_8000);
    chk({30'h0, prog_space, write_fault}, 32'h3);
    go(6'h3b, sw, 16'h3804);
    chk(ea_addr, 32'h0002_0004 + r(3));
    chk({30'h0, prog_space, write_fault}, 32'h3);
    @(posedge clk);
    write_op <= 1'b0;
    go(6'h3b, sw, 16'h1d30, 16'hffff, 16'hfff0);
    chk(ea_addr, 32'h0002_0000 + (r(1) << 2) + 32'hffff_fff0);
    chk({31'h0, prog_space}, 32'h1);
    go(6'h3b, sw, 16'h1db0, 16'hffff, 16'hfff0);
    chk(ea_addr, (r(1) << 2) + 32'hffff_fff0);
  endtask : t_pcrel

  task automatic t_special;
    go(6'h38, sw, 16'h8004);
    chk(ea_addr, 32'hffff_8004);
    go(6'h39, sw, 16'h1234, 16'h5678);
    chk(ea_addr, 32'h1234_5678);
    chk({29'h0, ext_count}, 32'h2);
    go(6'h3d, sw, 16'h0000);
    chk({31'h0, illegal}, 32'h1);
    chk(ea_addr, 32'h0);
    go(6'h3c, sb, 16'hab12);
    chk({31'h0, imm_valid}, 32'h1);
    chk({31'h0, prog_space}, 32'h1);
    chk(imm_data, 32'h12);
    go(6'h3c, sw, 16'hab12);
    chk(imm_data, 32'hab12);
    go(6'h3c, sl, 16'hab12, 16'h3456);
    chk(imm_data, 32'hab12_3456);
  endtask : t_special

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_direct();
    t_step();
    t_index();
    t_pcrel();
    t_special();
    end_of_test();
  end

  initial begin
    #16000;
    fails++;
    end_of_test();
  end
endmodule : effective_address_generator_tb_top
`default_nettype wire
